//--- rtl/ibr_defs.vh
`ifndef IBR_DEFS_VH
`define IBR_DEFS_VH

// Sys clock period in picoseconds (250 MHz).
`define IBR_CLK_PS 4000
// Least chip-select low and high phase, in nanoseconds.
`define IBR_SEL_LOW_NS 500
`define IBR_SEL_HIGH_NS 500
// Number of select pulses that make up the pattern.
`define IBR_PULSES 3'h4
// Default length of the internal reset, in sys clock cycles.
`define IBR_RESET_CYCLES 16'h0100
// Count width used by the reset timer.
`define IBR_CNT_W 16
`define IBR_CNT_ONE 16'h0001
`define IBR_CNT_ZERO 16'h0000

`endif

//--- rtl/ibr_sync.v
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for a vector of asynchronous levels.
module ibr_sync #(
  parameter WIDTH = 1
) (
  input wire sysClk,
  input wire nRst,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  always @(posedge sysClk or negedge nRst) begin
    if (!nRst) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule // ibr_sync

`default_nettype wire

//--- rtl/ibr_inband_reset_detector.v
// Notes on behaviour
// - Only select and data line zero form pattern.
// - Sample data line zero on select rising.
// - Low-high-low-high over four pulses starts reset.
// - Never drive data line before first clock; code still enables it in the select-fall cycle after a clocked frame.
// - Pattern recognised in every device state but reset.
// - Ignore select and commands during reset.
// - Resume normal command handling after reset.
// - Any reset releases error output, clears state.
`timescale 1ns/100ps
`default_nettype none
`include "ibr_defs.vh"

module ibr_inband_reset_detector #(
  parameter RESET_CYCLES = `IBR_RESET_CYCLES
) (
  input wire sysClk,
  input wire nrst,
  input wire selectN,
  input wire serialClk,
  input wire dataLineZeroIn,
  input wire coreDataOut,
  input wire coreDataOe,
  input wire coreClockSeen,
  input wire errEvent,
  input wire swResetReq,
  input wire hwResetN,
  output wire dataLineZeroOut,
  output wire dataLineZeroOe,
  output reg errOutN_reg,
  output wire errOutOe,
  output reg volatileClear_reg,
  output reg resetActive_reg,
  output wire coreSelectN,
  output reg patternDetect_reg
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RESET = 2'b10;

  reg rstSync1_reg;
  reg rstSync2_reg;
  wire rstN;

  always @(posedge sysClk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  assign rstN = rstSync2_reg;

  // Select and reset pins enter the synchroniser inverted, so its cleared state matches their
  // idle high level and no false select edge or reset pulse follows the release of reset.
  wire [3:0] syncVec;
  ibr_sync #(.WIDTH(4)) pinSync (
    .sysClk(sysClk),
    .nRst(rstN),
    .asyncIn({~selectN, serialClk, dataLineZeroIn, ~hwResetN}),
    .syncOut(syncVec)
  );
  wire selN = ~syncVec[3];
  wire sclk = syncVec[2];
  wire dq0 = syncVec[1];
  wire hwRstN = ~syncVec[0];

  reg selPrev_reg;
  reg sclkPrev_reg;
  reg [2:0] matchCnt_reg;
  reg [2:0] matchCnt_next;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`IBR_CNT_W-1:0] timer_reg;
  reg [`IBR_CNT_W-1:0] timer_next;
  reg clockInFrame_reg;

  wire selRise = selN & ~selPrev_reg;
  wire selFall = ~selN & selPrev_reg;
  wire sclkEdge = sclk ^ sclkPrev_reg;
  // Level expected on the next pulse: low on even, high on odd pulse counts.
  wire expected = matchCnt_reg[0];

  always @* begin
    matchCnt_next = matchCnt_reg;
    state_next = state_reg;
    timer_next = timer_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sclkEdge && !selN) begin
          matchCnt_next = 3'h0;
        end else if (selRise && !clockInFrame_reg) begin
          // Sampled on select rising regardless of core mode.
          if (dq0 == expected) begin
            matchCnt_next = matchCnt_reg + 3'h1;
          end else if (dq0 == 1'b0) begin
            matchCnt_next = 3'h1;
          end else begin
            matchCnt_next = 3'h0;
          end
          if (dq0 == expected && matchCnt_reg + 3'h1 == `IBR_PULSES) begin
            state_next = ST_RESET;
            timer_next = RESET_CYCLES[`IBR_CNT_W-1:0];
            matchCnt_next = 3'h0;
          end
        end else if (selRise) begin
          matchCnt_next = 3'h0;
        end
      end
      ST_RESET: begin
        // Select activity is not looked at while resetting.
        if (timer_reg == `IBR_CNT_ONE) begin
          state_next = ST_IDLE;
          timer_next = `IBR_CNT_ZERO;
        end else begin
          timer_next = timer_reg - `IBR_CNT_ONE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        matchCnt_next = 3'h0;
        timer_next = `IBR_CNT_ZERO;
      end
    endcase
  end

  wire anyReset = (state_next == ST_RESET) || swResetReq || !hwRstN;

  // Edge history of the synchronised pins; the select copy idles high like the pin itself.
  always @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      selPrev_reg <= 1'b1;
      sclkPrev_reg <= 1'b0;
    end else begin
      selPrev_reg <= selN;
      sclkPrev_reg <= sclk;
    end
  end

  always @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      matchCnt_reg <= 3'h0;
      state_reg <= ST_IDLE;
      timer_reg <= `IBR_CNT_ZERO;
    end else begin
      matchCnt_reg <= matchCnt_next;
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // A clock edge in the same cycle as the select fall belongs to the new frame, so setting
  // wins over clearing; otherwise that frame would still be counted as a reset pulse.
  always @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      clockInFrame_reg <= 1'b0;
    end else if (!selN && sclkEdge) begin
      clockInFrame_reg <= 1'b1;
    end else if (selFall) begin
      clockInFrame_reg <= 1'b0;
    end
  end

  always @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      errOutN_reg <= 1'b1;
      volatileClear_reg <= 1'b1;
      resetActive_reg <= 1'b0;
      patternDetect_reg <= 1'b0;
    end else begin
      patternDetect_reg <= (state_reg == ST_IDLE) && (state_next == ST_RESET);
      resetActive_reg <= (state_next == ST_RESET);
      volatileClear_reg <= anyReset;
      // Release wins over a new error event, since reset clears the error state.
      if (anyReset) begin
        errOutN_reg <= 1'b1;
      end else if (errEvent) begin
        errOutN_reg <= 1'b0;
      end
    end
  end

  // Core sees select held inactive during the reset, so commands are dropped.
  assign coreSelectN = (state_reg == ST_RESET) ? 1'b1 : selN;
  // Data line driven once a clock edge has been seen in this frame, and in the select-fall cycle that follows a clocked frame.
  assign dataLineZeroOe = coreDataOe && coreClockSeen && clockInFrame_reg && !selN
    && (state_reg == ST_IDLE);
  assign dataLineZeroOut = coreDataOut;
  // Open drain: the pin is pulled low only while the error is flagged.
  assign errOutOe = ~errOutN_reg;
endmodule // ibr_inband_reset_detector

`default_nettype wire

//--- testbench/ibr_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ibr_chk #(
  parameter RESET_CYCLES = 4
) (
  input wire sysClk,
  input wire nrst,
  input wire selectN,
  input wire coreDataOe,
  input wire dataLineZeroOe,
  input wire errOutN_reg,
  input wire volatileClear_reg,
  input wire resetActive_reg,
  input wire coreSelectN,
  input wire patternDetect_reg
);
  // Length of the standing in-band reset, so any parameter value can be checked.
  logic [15:0] rstLen;
  always @(posedge sysClk or negedge nrst) begin
    if (!nrst) begin
      rstLen <= 16'h0000;
    end else if (resetActive_reg) begin
      rstLen <= rstLen + 16'h0001;
    end else begin
      rstLen <= 16'h0000;
    end
  end
  default clocking @(posedge sysClk); endclocking
  default disable iff (!nrst);
  chk_oe_gated: assert property (dataLineZeroOe |-> coreDataOe)
    else $error("oe");
  chk_oe_selected: assert property (dataLineZeroOe |-> !coreSelectN && !resetActive_reg)
    else $error("oe outside frame");
  chk_detect_once: assert property (patternDetect_reg |=> !patternDetect_reg)
    else $error("det");
  chk_reset_cause: assert property ($rose(resetActive_reg) |-> patternDetect_reg)
    else $error("cause");
  chk_reset_len: assert property ($fell(resetActive_reg) |-> rstLen == RESET_CYCLES)
    else $error("len");
  chk_reset_bound: assert property (resetActive_reg |-> rstLen < RESET_CYCLES)
    else $error("reset too long");
  chk_select_held: assert property (resetActive_reg |-> coreSelectN)
    else $error("sel");
  chk_clear_inband: assert property (resetActive_reg |-> volatileClear_reg)
    else $error("clr");
  chk_err_release: assert property (volatileClear_reg |-> errOutN_reg)
    else $error("err");
  chk_sel_follow: assert property ((!selectN && !resetActive_reg)[*4] |-> !coreSelectN)
    else $error("follow");
  cover property (patternDetect_reg);
  cover property (!errOutN_reg);
  cover property (dataLineZeroOe);
  cover property (resetActive_reg && !selectN);
endmodule // ibr_chk
bind ibr_inband_reset_detector ibr_chk #(.RESET_CYCLES(RESET_CYCLES)) chk(.*);
`default_nettype wire

//--- testbench/ibr_host.sv
`timescale 1ns/100ps
`default_nettype none
module ibr_host (
  input wire logic sysClk,
  output logic selectN,
  output logic serialClk,
  output logic dataLineZeroIn
);
  // Recovery only: the host sends pulses when the bench asks.
  initial begin
    selectN = 1'h1;
    serialClk = 1'h0;
    dataLineZeroIn = 1'h1;
  end
  task automatic pulse(input logic lv, input logic tick);
    @(negedge sysClk);
    selectN = 1'h0;
    dataLineZeroIn = lv;
    repeat (125) @(negedge sysClk);
    if (tick) begin
      serialClk = 1'h1;
      repeat (6) @(negedge sysClk);
    end
    serialClk = 1'h0;
    selectN = 1'h1;
    repeat (3) @(negedge sysClk);
    // No pull on this line, so a released line shows the opposite level.
    dataLineZeroIn = ~lv;
    repeat (122) @(negedge sysClk);
  endtask
endmodule // ibr_host
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sysClk = 1'h0, nrst = 1'h0, coreDataOut = 1'h1, coreDataOe = 1'h0, coreClockSeen = 1'h1;
  logic errEvent = 1'h0, swResetReq = 1'h0, hwResetN = 1'h1, seen = 1'h0;
  logic oeSeen = 1'h0, outSeen = 1'h1, selLeak = 1'h0, lowInReset = 1'h0;
  wire selectN, serialClk, dataLineZeroIn, dataLineZeroOut, dataLineZeroOe, errOutN_reg;
  wire errOutOe, volatileClear_reg, resetActive_reg, coreSelectN, patternDetect_reg;
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #2 sysClk = ~sysClk;
  ibr_host host(.*);
  // Long enough that a whole legal select pulse falls inside the internal reset.
  ibr_inband_reset_detector #(.RESET_CYCLES(16'h0120)) uut(.*);
  task results;
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge sysClk) begin
    cyc++;
    if (patternDetect_reg) seen = 1'h1;
    if (dataLineZeroOe) begin
      oeSeen = 1'h1;
      outSeen = dataLineZeroOut;
    end
    if (resetActive_reg && !selectN) lowInReset = 1'h1;
    if (resetActive_reg && coreSelectN !== 1'h1) selLeak = 1'h1;
    if (cyc == 20000) begin
      n_errors++;
      results;
    end
  end
  task automatic chk(input string nm, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %b got %b", nm, e, s);
    end
  endtask
  task automatic send(input logic [7:0] lv, input int n, input logic [7:0] tk, input logic e);
    seen = 1'h0;
    for (int i = 0; i < n; i++) host.pulse(lv[i], tk[i]);
    chk("detect", e, seen);
    // Let a triggered internal reset run out before the next scenario starts.
    if (e) repeat (200) @(negedge sysClk);
  endtask
  task automatic errPulse;
    errEvent = 1'h1;
    @(negedge sysClk);
    errEvent = 1'h0;
    repeat (3) @(negedge sysClk);
    chk("errLow", 1'h0, errOutN_reg);
    chk("errOe", 1'h1, errOutOe);
  endtask
  task automatic tErrRelease;
    errPulse;
    send(8'h0A, 4, 8'h00, 1'h1);
    chk("errN", 1'h1, errOutN_reg);
    chk("errOeOff", 1'h0, errOutOe);
  endtask
  task automatic tBreak;
    send(8'h16, 5, 8'h00, 1'h0);
    send(8'h02, 2, 8'h00, 1'h1);
    send(8'h52, 7, 8'h00, 1'h1);
  endtask
  task automatic tClock;
    coreDataOe = 1'h1;
    send(8'h02, 2, 8'h00, 1'h0);
    chk("oeEarly", 1'h0, oeSeen);
    coreDataOut = 1'h0;
    send(8'h02, 2, 8'h01, 1'h0);
    chk("oeLate", 1'h1, oeSeen);
    chk("dqOut", 1'h0, outSeen);
    coreDataOe = 1'h0;
    coreDataOut = 1'h1;
    send(8'h0A, 4, 8'h00, 1'h1);
  endtask
  task automatic tOtherResets;
    for (int k = 0; k < 2; k++) begin
      errPulse;
      if (k == 0) swResetReq = 1'h1;
      else hwResetN = 1'h0;
      repeat (6) @(negedge sysClk);
      chk("clrOn", 1'h1, volatileClear_reg);
      swResetReq = 1'h0;
      hwResetN = 1'h1;
      repeat (6) @(negedge sysClk);
      chk("errN", 1'h1, errOutN_reg);
      chk("clrOff", 1'h0, volatileClear_reg);
    end
  endtask
  // A full pulse sent while the internal reset stands must not count towards a new pattern.
  task automatic tDuringReset;
    seen = 1'h0;
    for (int i = 0; i < 4; i++) host.pulse(i[0], 1'h0);
    chk("detect", 1'h1, seen);
    host.pulse(1'h0, 1'h0);
    chk("lowInReset", 1'h1, lowInReset);
    chk("selHeld", 1'h0, selLeak);
    send(8'h05, 3, 8'h00, 1'h0);
  endtask
  initial begin
    repeat (16) @(negedge sysClk);
    nrst = 1'h1;
    repeat (4) @(negedge sysClk);
    tErrRelease;
    tBreak;
    tClock;
    tOtherResets;
    tDuringReset;
    results;
  end
endmodule // tb_top
`default_nettype wire
